// [sre_pkg.sv]
// Shared types and constants for the sleep/return/subtract/rotate executor.
// Assumes the core decoder presents one decoded instruction at a time.
package sre_pkg;

  // ==========================================================================
  // Widths, reset values, destination codes and carry bit positions
  localparam int          SRE_DATA_W     = 8;
  localparam int          SRE_FADDR_W    = 7;
  localparam int          SRE_PC_W       = 13;
  localparam int          SRE_STACK_D    = 8;
  localparam logic [7:0]  SRE_ACC_RST    = 8'h00;
  localparam logic [7:0]  SRE_WDT_ZERO   = 8'h00;
  localparam logic [12:0] SRE_PC_RST     = 13'h0000;
  localparam logic        SRE_TO_N_RST   = 1'b1;
  localparam logic        SRE_PD_N_RST   = 1'b1;
  localparam logic        SRE_DEST_ACC   = 1'b0;
  localparam logic        SRE_DEST_FILE  = 1'b1;
  localparam int          SRE_NIB_CARRY  = 4;
  localparam int          SRE_BYTE_CARRY = 8;

  // ==========================================================================
  // Decoded instruction kinds handled here
  typedef enum logic [2:0] {
    SRE_OP_NONE,
    SRE_OP_SLEEP,
    SRE_OP_RETURN,
    SRE_OP_SUB_FROM_LITERAL,
    SRE_OP_SUB_ACC_FROM_FILE,
    SRE_OP_ROTATE_RIGHT_CARRY
  } sre_op_t;

  typedef struct packed {
    sre_op_t          op;
    logic [7:0]       literal;
    logic [6:0]       file_addr;
    logic             dest;
  } sre_instr_t;

  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } sre_status_t;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } sre_file_wr_t;

endpackage : sre_pkg

// [sre_exec.sv]
// Executor for the low-power, subroutine return, two subtract forms and
// rotate-right-through-carry instructions of an 8-bit core.
// Assumes file read data for the addressed register is valid with the issue,
// and that the decoder issues only while issue_ready is high.
`timescale 1ns/10ps

module sre_exec
  import sre_pkg::*;
#(
  parameter int STACK_DEPTH = SRE_STACK_D
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // Decoded instruction and file operand
  input  wire logic             issue_valid,
  input  wire sre_instr_t       issue,
  input  wire logic [7:0]       file_rdata,
  output logic                  issue_ready,
  // Call side of the hardware stack
  input  wire logic             push_valid,
  input  wire logic [12:0]      push_addr,
  // Wake-up request from outside the clock domain
  input  wire logic             wake_pin,
  // Results
  output logic [7:0]            acc,
  output sre_status_t           status,
  output sre_file_wr_t          file_wr,
  output logic [12:0]           pc,
  output logic                  pc_load,
  output logic                  flush,
  output logic                  watchdog_timer_clr,
  output logic [7:0]            watchdog_timer_val,
  output logic                  osc_stop
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {SRE_ST_RUN, SRE_ST_RET, SRE_ST_SLEEP} sre_state_t;

  localparam int SP_W = $clog2(STACK_DEPTH);

  sre_state_t      state_q;
  logic [7:0]      acc_q;
  sre_status_t     status_q;
  sre_file_wr_t    file_wr_q;
  logic [12:0]     pc_q;
  logic            pc_load_q;
  logic            flush_q;
  logic            wdt_clr_q;
  logic [7:0]      wdt_val_q;
  logic            ready_q;
  logic            osc_stop_q;
  logic            wake_s1_q;
  logic            wake_s2_q;
  logic [SP_W-1:0] sp_q;
  logic [12:0]     stack_q [STACK_DEPTH];

  logic            go;
  logic [8:0]      sub_sum;
  logic [4:0]      nib_sum;
  logic [7:0]      sub_a;
  logic [7:0]      rot_res;
  logic [SP_W-1:0] sp_top;

  assign go     = clk_en && issue_valid && ready_q;
  assign sp_top = sp_q - SP_W'(1);

  // ==========================================================================
  // Arithmetic
  always_comb begin
    sub_a = (issue.op == SRE_OP_SUB_FROM_LITERAL) ? issue.literal : file_rdata;
    // Two's complement: a + ~w + 1, carry out means no borrow
    sub_sum = {1'b0, sub_a} + {1'b0, ~acc_q} + 9'h001;
    nib_sum = {1'b0, sub_a[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
    rot_res = {status_q.carry, file_rdata[7:1]};
  end

  // ==========================================================================
  // Wake-up synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else if (clk_en) begin
      wake_s1_q <= wake_pin;
      wake_s2_q <= wake_s1_q;
    end
  end

  // ==========================================================================
  // Sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= SRE_ST_RUN;
      ready_q    <= 1'b1;
      flush_q    <= 1'b0;
      osc_stop_q <= 1'b0;
    end else if (clk_en) begin
      flush_q <= 1'b0;
      case (state_q)
        SRE_ST_RUN: begin
          if (go && issue.op == SRE_OP_RETURN) begin
            state_q <= SRE_ST_RET;
            ready_q <= 1'b0;
          end else if (go && issue.op == SRE_OP_SLEEP) begin
            state_q    <= SRE_ST_SLEEP;
            ready_q    <= 1'b0;
            osc_stop_q <= 1'b1;
          end
        end
        SRE_ST_RET: begin
          // Second cycle discards the instruction fetched behind the return
          flush_q <= 1'b1;
          state_q <= SRE_ST_RUN;
          ready_q <= 1'b1;
        end
        SRE_ST_SLEEP: begin
          if (wake_s2_q) begin
            state_q    <= SRE_ST_RUN;
            ready_q    <= 1'b1;
            osc_stop_q <= 1'b0;
          end
        end
        default: begin
          state_q    <= SRE_ST_RUN;
          ready_q    <= 1'b1;
          osc_stop_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Accumulator and status flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q                     <= SRE_ACC_RST;
      status_q                  <= '0;
      status_q.timeout_flag_n   <= SRE_TO_N_RST;
      status_q.powerdown_flag_n <= SRE_PD_N_RST;
    end else if (go) begin
      case (issue.op)
        SRE_OP_SLEEP: begin
          status_q.powerdown_flag_n <= 1'b0;
          status_q.timeout_flag_n   <= 1'b1;
        end
        SRE_OP_SUB_FROM_LITERAL: begin
          acc_q                      <= sub_sum[7:0];
          status_q.carry             <= sub_sum[SRE_BYTE_CARRY];
          status_q.nibble_carry_flag <= nib_sum[SRE_NIB_CARRY];
          status_q.zero              <= (sub_sum[7:0] == 8'h00);
        end
        SRE_OP_SUB_ACC_FROM_FILE: begin
          if (issue.dest == SRE_DEST_ACC) begin
            acc_q <= sub_sum[7:0];
          end
          status_q.carry             <= sub_sum[SRE_BYTE_CARRY];
          status_q.nibble_carry_flag <= nib_sum[SRE_NIB_CARRY];
          status_q.zero              <= (sub_sum[7:0] == 8'h00);
        end
        SRE_OP_ROTATE_RIGHT_CARRY: begin
          if (issue.dest == SRE_DEST_ACC) begin
            acc_q <= rot_res;
          end
          status_q.carry <= file_rdata[0];
        end
        default: begin
          acc_q <= acc_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // File register write-back
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wr_q <= '0;
    end else if (clk_en) begin
      file_wr_q.wr <= 1'b0;
      if (go && issue.dest == SRE_DEST_FILE) begin
        if (issue.op == SRE_OP_SUB_ACC_FROM_FILE) begin
          file_wr_q <= '{wr: 1'b1, addr: issue.file_addr, data: sub_sum[7:0]};
        end else if (issue.op == SRE_OP_ROTATE_RIGHT_CARRY) begin
          file_wr_q <= '{wr: 1'b1, addr: issue.file_addr, data: rot_res};
        end
      end
    end
  end

  // ==========================================================================
  // Watchdog clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_clr_q <= 1'b0;
      wdt_val_q <= SRE_WDT_ZERO;
    end else if (clk_en) begin
      // Pulse zeroes both count and prescaler in the watchdog block
      wdt_clr_q <= go && issue.op == SRE_OP_SLEEP;
      wdt_val_q <= SRE_WDT_ZERO;
    end
  end

  // ==========================================================================
  // Hardware stack and program counter
  // The stack wraps silently on overflow; there is no overflow flag.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q      <= '0;
      pc_q      <= SRE_PC_RST;
      pc_load_q <= 1'b0;
    end else if (clk_en) begin
      pc_load_q <= 1'b0;
      if (go && issue.op == SRE_OP_RETURN) begin
        pc_q      <= stack_q[sp_top];
        pc_load_q <= 1'b1;
        sp_q      <= sp_top;
      end else if (push_valid) begin
        sp_q <= sp_q + SP_W'(1);
      end
    end
  end

  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stack_q[i] <= SRE_PC_RST;
        end else if (clk_en && push_valid && !(go && issue.op == SRE_OP_RETURN)
                     && sp_q == SP_W'(i)) begin
          stack_q[i] <= push_addr;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Outputs
  assign issue_ready        = ready_q;
  assign acc                = acc_q;
  assign status             = status_q;
  assign file_wr            = file_wr_q;
  assign pc                 = pc_q;
  assign pc_load            = pc_load_q;
  assign flush              = flush_q;
  assign watchdog_timer_clr = wdt_clr_q;
  assign watchdog_timer_val = wdt_val_q;
  assign osc_stop           = osc_stop_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sleep_wdt: assert property (go && issue.op == SRE_OP_SLEEP
    |=> watchdog_timer_clr && watchdog_timer_val == 8'h00)
    else $error("watchdog not cleared by sleep");
  a_sleep_flags: assert property (go && issue.op == SRE_OP_SLEEP
    |=> !status.powerdown_flag_n && status.timeout_flag_n
        && $stable({status.carry, status.nibble_carry_flag, status.zero}))
    else $error("sleep status flags wrong");
  a_sleep_halt: assert property (osc_stop && !wake_s2_q |=> osc_stop && !issue_ready)
    else $error("core left sleep without wake");
  a_ret_pc: assert property (go && issue.op == SRE_OP_RETURN
    |=> pc_load && pc == $past(stack_q[sp_top]) && $stable(status))
    else $error("return pc or flags wrong");
  a_ret_flush: assert property (go && issue.op == SRE_OP_RETURN ##1 clk_en
    |=> flush && issue_ready)
    else $error("return flush missing");
  a_sub_lit: assert property (go && issue.op == SRE_OP_SUB_FROM_LITERAL
    |=> acc == 8'($past(issue.literal) - $past(acc))
        && status.carry == ($past(issue.literal) >= $past(acc)))
    else $error("literal subtract wrong");
  a_rot_carry: assert property (go && issue.op == SRE_OP_ROTATE_RIGHT_CARRY
    |=> status.carry == $past(file_rdata[0]) && $stable(status.zero))
    else $error("rotate carry wrong");
  a_rot_dest: assert property (go && issue.op == SRE_OP_ROTATE_RIGHT_CARRY && issue.dest
    |=> file_wr.wr && file_wr.data == {$past(status.carry), $past(file_rdata[7:1])}
        && $stable(acc))
    else $error("rotate write-back wrong");
  a_subf_flags: assert property (go && issue.op == SRE_OP_SUB_ACC_FROM_FILE
    |=> status.carry == ($past(file_rdata) >= $past(acc))
        && status.nibble_carry_flag == ($past(file_rdata[3:0]) >= $past(acc[3:0])))
    else $error("file subtract flags wrong");
  a_subf_dest: assert property (go && issue.op == SRE_OP_SUB_ACC_FROM_FILE && !issue.dest
    |=> acc == 8'($past(file_rdata) - $past(acc)) && !file_wr.wr)
    else $error("file subtract to accumulator wrong");

  c_sleep_wake: cover property (osc_stop ##1 !osc_stop);
  c_return:     cover property (go && issue.op == SRE_OP_RETURN ##2 flush);
  c_sub_zero:   cover property (go && issue.op == SRE_OP_SUB_FROM_LITERAL ##1 status.zero);
  c_rot_file:   cover property (go && issue.op == SRE_OP_ROTATE_RIGHT_CARRY && issue.dest);

endmodule : sre_exec

// [sre_exec_tb.sv]
// Self-checking testbench for the sleep/return/subtract/rotate executor.
// Assumes one instance of sre_exec at a 200 MHz clock, with the bench driving every port.
`timescale 1ns/10ps

module sre_exec_tb
  import sre_pkg::*;
();
  // ==========================================================================
  // Design signals
  logic         clk;
  logic         rst_b;
  logic         clk_en;
  logic         issue_valid;
  sre_instr_t   issue;
  logic [7:0]   file_rdata;
  logic         issue_ready;
  logic         push_valid;
  logic [12:0]  push_addr;
  logic         wake_pin;
  logic [7:0]   acc;
  sre_status_t  status;
  sre_file_wr_t file_wr;
  logic [12:0]  pc;
  logic         pc_load;
  logic         flush;
  logic         watchdog_timer_clr;
  logic [7:0]   watchdog_timer_val;
  logic         osc_stop;
  int           miscompares;
  int           n_tests;
  int           cycles;
  logic [7:0]   m_acc;
  logic [4:0]   m_st;

  sre_exec sre_exec_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .issue_valid(issue_valid), .issue(issue),
    .file_rdata(file_rdata), .issue_ready(issue_ready), .push_valid(push_valid), .push_addr(push_addr),
    .wake_pin(wake_pin), .acc(acc), .status(status), .file_wr(file_wr), .pc(pc), .pc_load(pc_load),
    .flush(flush), .watchdog_timer_clr(watchdog_timer_clr), .watchdog_timer_val(watchdog_timer_val),
    .osc_stop(osc_stop));

  // ==========================================================================
  // Clock, timeout, compare helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run is about 60 cycles; the ceiling of 2000 leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  // Borrow-free subtract reference: {carry, nibble carry, difference}
  function automatic logic [9:0] sub_ref(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {a >= b, a[3:0] >= b[3:0], r};
  endfunction : sub_ref

  task automatic do_op(input sre_op_t op, input logic [7:0] lit, input logic [6:0] fa, input logic d,
                       input logic [7:0] fd);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue       <= '{op: op, literal: lit, file_addr: fa, dest: d};
    file_rdata  <= fd;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
  endtask : do_op

  task automatic chk_core();
    chk_val("acc", {8'h00, m_acc}, {8'h00, acc});
    chk_val("status", {11'h000, m_st}, {11'h000, status});
  endtask : chk_core

  // ==========================================================================
  // Scenarios
  task automatic t_sub_lit();
    logic [7:0] lits [4] = '{8'h05, 8'h03, 8'hFE, 8'h10};
    logic [9:0] r;
    foreach (lits[i]) begin
      r = sub_ref(lits[i], m_acc);
      do_op(SRE_OP_SUB_FROM_LITERAL, lits[i], 7'h00, SRE_DEST_FILE, 8'h00);
      m_acc = r[7:0];
      m_st[4:2] = {r[9], r[8], r[7:0] == 8'h00};
      chk_core();
      chk_bit("file_wr.wr", 1'b0, file_wr.wr);
    end
  endtask : t_sub_lit

  task automatic t_sub_file();
    logic [9:0] r;
    r = sub_ref(8'h0F, m_acc);
    do_op(SRE_OP_SUB_ACC_FROM_FILE, 8'h00, 7'h7F, SRE_DEST_FILE, 8'h0F);
    m_st[4:2] = {r[9], r[8], r[7:0] == 8'h00};
    chk_core();
    chk_val("file_wr", {1'b1, 7'h7F, r[7:0]}, file_wr);
    r = sub_ref(8'h10, m_acc);
    do_op(SRE_OP_SUB_ACC_FROM_FILE, 8'h00, 7'h00, SRE_DEST_ACC, 8'h10);
    m_acc = r[7:0];
    m_st[4:2] = {r[9], r[8], r[7:0] == 8'h00};
    chk_core();
    chk_bit("file_wr.wr", 1'b0, file_wr.wr);
  endtask : t_sub_file

  task automatic t_rotate();
    logic [7:0] e;
    e = {m_st[4], 7'h40};
    do_op(SRE_OP_ROTATE_RIGHT_CARRY, 8'h00, 7'h15, SRE_DEST_FILE, 8'h81);
    m_st[4] = 1'b1;
    chk_core();
    chk_val("file_wr", {1'b1, 7'h15, e}, file_wr);
    do_op(SRE_OP_ROTATE_RIGHT_CARRY, 8'h00, 7'h15, SRE_DEST_ACC, 8'h02);
    m_acc = 8'h81;
    m_st[4] = 1'b0;
    chk_core();
    chk_bit("file_wr.wr", 1'b0, file_wr.wr);
  endtask : t_rotate

  task automatic t_return();
    logic [12:0] addrs [2] = '{13'h0123, 13'h1ABC};
    foreach (addrs[i]) begin
      @(posedge clk);
      push_valid <= 1'b1;
      push_addr  <= addrs[i];
      @(posedge clk);
      push_valid <= 1'b0;
    end
    for (int i = 1; i >= 0; i--) begin
      do_op(SRE_OP_RETURN, 8'h00, 7'h00, SRE_DEST_ACC, 8'h00);
      chk_val("pc", {3'h0, addrs[i]}, {3'h0, pc});
      chk_bit("pc_load", 1'b1, pc_load);
      chk_bit("issue_ready", 1'b0, issue_ready);
      chk_core();
      @(posedge clk);
      #1;
      chk_bit("flush", 1'b1, flush);
      chk_bit("issue_ready", 1'b1, issue_ready);
    end
  endtask : t_return

  task automatic t_sleep();
    int n;
    do_op(SRE_OP_SLEEP, 8'h00, 7'h00, SRE_DEST_ACC, 8'h00);
    m_st[1:0] = 2'b10;
    chk_bit("watchdog_timer_clr", 1'b1, watchdog_timer_clr);
    chk_val("watchdog_timer_val", 16'h0000, {8'h00, watchdog_timer_val});
    chk_core();
    chk_bit("osc_stop", 1'b1, osc_stop);
    // An instruction offered while asleep must not run
    @(posedge clk);
    issue_valid <= 1'b1;
    issue       <= '{op: SRE_OP_SUB_FROM_LITERAL, literal: 8'h55, file_addr: 7'h00, dest: SRE_DEST_ACC};
    repeat (5) @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    chk_core();
    chk_bit("osc_stop", 1'b1, osc_stop);
    chk_bit("issue_ready", 1'b0, issue_ready);
    @(posedge clk);
    wake_pin <= 1'b1;
    n = 0;
    // Two synchroniser stages plus the state step
    while (issue_ready !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val("wake_cycles", 16'h0003, 16'(n));
    chk_bit("issue_ready", 1'b1, issue_ready);
    chk_bit("osc_stop", 1'b0, osc_stop);
    @(posedge clk);
    wake_pin <= 1'b0;
  endtask : t_sleep

  // Clock enable low freezes the core: an offered instruction waits for it
  task automatic t_hold();
    logic [9:0] r;
    r = sub_ref(8'h3C, m_acc);
    @(posedge clk);
    clk_en      <= 1'b0;
    issue_valid <= 1'b1;
    issue       <= '{op: SRE_OP_SUB_FROM_LITERAL, literal: 8'h3C, file_addr: 7'h00, dest: SRE_DEST_ACC};
    repeat (3) @(posedge clk);
    #1;
    chk_core();
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    m_acc = r[7:0];
    m_st[4:2] = {r[9], r[8], r[7:0] == 8'h00};
    chk_core();
  endtask : t_hold

  // ==========================================================================
  // Main sequence
  initial begin
    miscompares = 0;
    n_tests     = 0;
    cycles      = 0;
    rst_b       = 1'b0;
    clk_en      = 1'b1;
    issue_valid = 1'b0;
    issue       = '0;
    file_rdata  = 8'h00;
    push_valid  = 1'b0;
    push_addr   = 13'h0000;
    wake_pin    = 1'b0;
    m_acc       = 8'h00;
    m_st        = 5'h03;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk_core();
    chk_bit("issue_ready", 1'b1, issue_ready);
    t_sub_lit();
    t_sub_file();
    t_rotate();
    t_return();
    t_sleep();
    t_sub_lit();
    t_hold();
    tally_and_finish();
  end

endmodule : sre_exec_tb
